/* src/bta_params.svh */
`ifndef BTA_PARAMS_SVH
`define BTA_PARAMS_SVH

// Avalon-MM byte address width and data width
`define BTA_AW 8
`define BTA_DW 32

// Register byte offsets
`define BTA_OFF_CTRL 8'h00
`define BTA_OFF_STATUS 8'h04
`define BTA_OFF_INT_STAT 8'h08
`define BTA_OFF_INT_MASK 8'h0c
`define BTA_OFF_TCOUNT 8'h10
`define BTA_OFF_REMAIN 8'h14
`define BTA_OFF_STORED 8'h18
`define BTA_OFF_TIDX 8'h1c
`define BTA_OFF_TLO 8'h20
`define BTA_OFF_THI 8'h24
// Comparator block: 0x40 + 0x10 * n, words cfg / value a / value b
`define BTA_CMP_PAGE 2'h1
`define BTA_CMP_CFG 2'h0
`define BTA_CMP_VA 2'h1
`define BTA_CMP_VB 2'h2
`define BTA_NCMP 4

// Control fields
`define BTA_CTRL_ARM 0
`define BTA_CTRL_MODE_LSB 1
`define BTA_CTRL_STOP 4

// Recording mode codes
`define BTA_MODE_CONT_ALL 3'h0
`define BTA_MODE_CONT_EV 3'h1
`define BTA_MODE_CNT_ALL 3'h2
`define BTA_MODE_CNT_EV 3'h3
`define BTA_MODE_SEQ_ANY 3'h4

// Interrupt status / mask bits
`define BTA_INT_DONE 0
`define BTA_INT_TRIG 1
`define BTA_INT_BRK 2
`define BTA_INT_W 3

// Comparator configuration fields
`define BTA_CFG_EN 0
`define BTA_CFG_RANGE 1
`define BTA_CFG_BRK 2
`define BTA_CFG_RW_CARE 3
`define BTA_CFG_RW_VAL 4
`define BTA_CFG_INS_CARE 5
`define BTA_CFG_INS_VAL 6
`define BTA_CFG_EXT_CARE 7
`define BTA_CFG_EXT_VAL 8
`define BTA_CFG_PMASK_LSB 9
`define BTA_CFG_PVAL_LSB 14
`define BTA_EV_PROBES 5

// Trace buffer and counters
`define BTA_DEPTH 64
`define BTA_PTR_W 6
`define BTA_CNT_W 16
`define BTA_TCOUNT_RST 16'h1000
`define BTA_PROBES 24
`define BTA_SAMPLE_W 59

`endif

/* src/bta_pkg.sv */
`include "bta_params.svh"

package bta_pkg;
  // Analyzer sequencing states, one-hot
  typedef enum logic [4:0] {
    BTA_IDLE = 5'h01,
    BTA_ARMED = 5'h02,
    BTA_RUN = 5'h04,
    BTA_POST = 5'h08,
    BTA_DONE = 5'h10
  } bta_state_t;

  // One stored frame: probes, ext, instr, rw, address, data
  typedef logic [`BTA_SAMPLE_W-1:0] bta_sample_t;
endpackage

/* src/bta_comparator.sv */
`timescale 1ns/10ps
`include "bta_params.svh"

module bta_comparator (
  // Programmed criteria
  input wire logic [31:0] cfg,
  input wire logic [31:0] val_a,
  input wire logic [31:0] val_b,
  // Sampled bus
  input wire logic [31:0] bus_word,
  input wire logic bus_rw,
  input wire logic bus_instr,
  input wire logic bus_ext,
  input wire logic [`BTA_EV_PROBES-1:0] probe_ev,
  // Result
  output logic match
);
  // Term form: value a compared under mask b
  wire term_hit = ((bus_word ^ val_a) & val_b) == 32'h0;
  // Range form: inclusive bounds on any 32-bit input
  wire range_hit = (bus_word >= val_a) && (bus_word <= val_b);
  wire val_hit = cfg[`BTA_CFG_RANGE] ? range_hit : term_hit;
  // Cycle attributes, each may be ignored
  wire rw_ok = ~cfg[`BTA_CFG_RW_CARE] | (bus_rw == cfg[`BTA_CFG_RW_VAL]);
  wire ins_ok = ~cfg[`BTA_CFG_INS_CARE] | (bus_instr == cfg[`BTA_CFG_INS_VAL]);
  wire ext_ok = ~cfg[`BTA_CFG_EXT_CARE] | (bus_ext == cfg[`BTA_CFG_EXT_VAL]);
  // Only the five event probes enter here
  wire [`BTA_EV_PROBES-1:0] pmask = cfg[`BTA_CFG_PMASK_LSB +: `BTA_EV_PROBES];
  wire [`BTA_EV_PROBES-1:0] pval = cfg[`BTA_CFG_PVAL_LSB +: `BTA_EV_PROBES];
  wire probe_ok = ((probe_ev ^ pval) & pmask) == 5'h00;
  // All criteria together, gated by own enable
  assign match = cfg[`BTA_CFG_EN] & val_hit & rw_ok & ins_ok & ext_ok & probe_ok;
endmodule // bta_comparator

/* src/bta_top.sv */
// What this block does
// - Sample whole bus at each target cycle end
// - Every stored frame carries all 24 probes
// - Four comparators A-D, each separately enabled
// - Match address, data, access, type, extended, probes
// - Only five pod A probes feed comparators
// - Range form matches between two 32-bit bounds
// - Breakpoint option turns match into halt request
// - Stop option halts target when recording completes
// - Armed analyzer stores nothing before execution starts
// - Mode, with comparators and count, selects which cycles get stored
// - Continuous all: store every cycle until stop
// - Continuous events: store matching cycles only
// - Counted all: store count cycles, stop early
// - Counted events: store matches up to count
// - Single event: trigger, then post-trigger count
// - Terminal count used only by counted, sequential
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`include "bta_params.svh"

module bta_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [`BTA_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`BTA_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [`BTA_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Target bus, one strobe per target cycle
  input wire logic tgt_cycle_end,
  input wire logic tgt_running,
  input wire logic [23:0] tgt_addr,
  input wire logic [7:0] tgt_data,
  input wire logic tgt_rw,
  input wire logic tgt_instr,
  input wire logic tgt_ext,
  input wire logic [`BTA_PROBES-1:0] tgt_probe,
  // Toward the target and host
  output logic halt_req,
  output logic irq
);
  // Merge a bus write into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Reset release synchroniser
  logic rst_meta_reg;
  logic rst_sync_reg;
  wire rst_n = rst_sync_reg; // Released copy used everywhere

  // Two flops; assertion is immediate, release is clocked
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Bus handshake: one wait cycle on every access
  logic ack_reg;
  logic [31:0] readdata_reg;
  wire req = avs_read | avs_write;
  wire wr_go = avs_write & ack_reg; // Write lands at the edge waitrequest is low
  wire rd_first = avs_read & ~ack_reg; // Read data captured one cycle early
  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata = readdata_reg;

  // Address decode
  wire hit_ctrl = avs_address == `BTA_OFF_CTRL;
  wire hit_status = avs_address == `BTA_OFF_STATUS;
  wire hit_istat = avs_address == `BTA_OFF_INT_STAT;
  wire hit_imask = avs_address == `BTA_OFF_INT_MASK;
  wire hit_tcount = avs_address == `BTA_OFF_TCOUNT;
  wire hit_remain = avs_address == `BTA_OFF_REMAIN;
  wire hit_stored = avs_address == `BTA_OFF_STORED;
  wire hit_tidx = avs_address == `BTA_OFF_TIDX;
  wire hit_tlo = avs_address == `BTA_OFF_TLO;
  wire hit_thi = avs_address == `BTA_OFF_THI;
  wire hit_cmp = avs_address[7:6] == `BTA_CMP_PAGE;
  wire [1:0] cmp_idx = avs_address[5:4];
  wire [1:0] cmp_word = avs_address[3:2];

  // Software registers
  logic [2:0] mode_reg; // Recording mode
  logic stop_reg; // Halt target on completion
  logic [`BTA_CNT_W-1:0] tcount_reg; // Terminal / post-trigger count
  logic [`BTA_INT_W-1:0] istat_reg; // Sticky events
  logic [`BTA_INT_W-1:0] imask_reg; // Interrupt enables
  logic [`BTA_PTR_W-1:0] tidx_reg; // Trace readout index
  logic [31:0] cmp_cfg_reg [`BTA_NCMP];
  logic [31:0] cmp_va_reg [`BTA_NCMP];
  logic [31:0] cmp_vb_reg [`BTA_NCMP];

  // Analyzer state
  bta_pkg::bta_state_t state_reg;
  bta_pkg::bta_state_t state_next;
  logic [`BTA_CNT_W-1:0] cnt_reg; // Down-counter
  logic [`BTA_CNT_W-1:0] cnt_next;
  logic [`BTA_PTR_W-1:0] wptr_reg; // Next trace slot
  logic [`BTA_CNT_W-1:0] stored_reg; // Frames stored, saturating
  logic wrapped_reg; // Buffer filled once, next store overwrites oldest
  logic halt_reg;
  bta_pkg::bta_sample_t trace_mem [`BTA_DEPTH]; // Trace buffer

  // Arm and disarm commands from the control word
  wire ctrl_wr = wr_go & hit_ctrl & avs_byteenable[0];
  wire arm_load = ctrl_wr & avs_writedata[`BTA_CTRL_ARM];
  wire disarm = ctrl_wr & ~avs_writedata[`BTA_CTRL_ARM];

  // Sample assembly from the bus at cycle end
  wire [31:0] bus_word = {tgt_addr, tgt_data};
  wire bta_pkg::bta_sample_t sample = {tgt_probe, tgt_ext, tgt_instr, tgt_rw, bus_word};

  // Four comparators on the same sampled cycle
  logic [`BTA_NCMP-1:0] cmp_match;
  logic [`BTA_NCMP-1:0] cmp_brk;
  for (genvar g = 0; g < `BTA_NCMP; g++) begin : g_cmp
    bta_comparator u_cmp (
      .cfg(cmp_cfg_reg[g]),
      .val_a(cmp_va_reg[g]),
      .val_b(cmp_vb_reg[g]),
      .bus_word(bus_word),
      .bus_rw(tgt_rw),
      .bus_instr(tgt_instr),
      .bus_ext(tgt_ext),
      .probe_ev(tgt_probe[`BTA_EV_PROBES-1:0]),
      .match(cmp_match[g])
    );
    assign cmp_brk[g] = cmp_cfg_reg[g][`BTA_CFG_BRK];
  end

  // Mode classes
  wire counted = (mode_reg == `BTA_MODE_CNT_ALL) | (mode_reg == `BTA_MODE_CNT_EV);
  wire events_only = (mode_reg == `BTA_MODE_CONT_EV) | (mode_reg == `BTA_MODE_CNT_EV);
  wire seq_mode = mode_reg == `BTA_MODE_SEQ_ANY;
  wire any_match = |cmp_match;
  wire brk_hit = |(cmp_match & cmp_brk);

  // Cycle qualification: only a completed target cycle with execution running
  wire in_armed = state_reg == bta_pkg::BTA_ARMED;
  wire in_run = state_reg == bta_pkg::BTA_RUN;
  wire in_post = state_reg == bta_pkg::BTA_POST;
  wire exec_cyc = tgt_cycle_end & tgt_running;
  wire start = in_armed & exec_cyc; // First executed cycle
  wire active_cyc = exec_cyc & (in_run | in_post | in_armed);
  wire halted = (in_run | in_post) & ~tgt_running; // Execution stopped

  // Count gating: counted modes, and the post-trigger phase
  wire cnt_gate = (counted & ~in_post) | in_post;
  wire cnt_zero = cnt_reg == 16'h0000;
  wire cnt_one = cnt_reg == 16'h0001;
  wire pick = events_only ? any_match : 1'b1;
  wire store_en = active_cyc & pick & ~(cnt_gate & cnt_zero);

  // Termination and trigger events
  wire brk_stop = active_cyc & brk_hit;
  wire fin_count = active_cyc & cnt_gate & (cnt_zero | (store_en & cnt_one));
  wire trigger = active_cyc & seq_mode & ~in_post & any_match;
  wire complete = fin_count & ~brk_stop;

  // Next state, highest priority first
  always_comb begin
    state_next = state_reg;
    if (arm_load) begin
      state_next = bta_pkg::BTA_ARMED;
    end else if (disarm) begin
      state_next = bta_pkg::BTA_IDLE;
    end else if (halted | brk_stop | fin_count) begin
      state_next = bta_pkg::BTA_DONE;
    end else if (trigger) begin
      state_next = bta_pkg::BTA_POST;
    end else if (start) begin
      state_next = bta_pkg::BTA_RUN;
    end
  end

  // Down-counter: load on arm or trigger, step per stored cycle under count gating
  always_comb begin
    cnt_next = cnt_reg;
    if (arm_load | trigger) begin
      cnt_next = tcount_reg;
    end else if (store_en & cnt_gate) begin
      cnt_next = cnt_reg - 16'h0001;
    end
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= bta_pkg::BTA_IDLE;
      cnt_reg <= 16'h0000;
      halt_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      // Breakpoint works whether or not tracing is on
      halt_reg <= (exec_cyc & brk_hit) | (complete & stop_reg);
    end
  end
  assign halt_req = halt_reg;

  // Write pointer and stored count; buffer wraps, keeping newest frames
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= 6'h00;
      stored_reg <= 16'h0000;
      wrapped_reg <= 1'b0;
    end else if (arm_load) begin
      wptr_reg <= 6'h00;
      stored_reg <= 16'h0000;
      wrapped_reg <= 1'b0;
    end else if (store_en) begin
      wptr_reg <= wptr_reg + 6'h01;
      stored_reg <= (stored_reg == 16'hffff) ? stored_reg : stored_reg + 16'h0001;
      wrapped_reg <= wrapped_reg | (wptr_reg == 6'h3f);
    end
  end

  // Trace buffer, no reset on the array
  always_ff @(posedge sys_clk) begin
    if (store_en) begin
      trace_mem[wptr_reg] <= sample;
    end
  end

  // Interrupt events; set wins over a same-cycle clear
  wire [`BTA_INT_W-1:0] ev_set = {brk_stop, trigger, complete | halted | brk_stop};
  wire [`BTA_INT_W-1:0] ev_clr = (wr_go & hit_istat & avs_byteenable[0]) ?
                                 avs_writedata[`BTA_INT_W-1:0] : 3'h0;
  assign irq = |(istat_reg & imask_reg);
  wire [31:0] tcount_merged = be_merge({16'h0000, tcount_reg}, avs_writedata, avs_byteenable);

  // Control, count, mask and sticky status registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `BTA_MODE_CONT_ALL;
      stop_reg <= 1'b0;
      tcount_reg <= `BTA_TCOUNT_RST;
      istat_reg <= 3'h0;
      imask_reg <= 3'h0;
      tidx_reg <= 6'h00;
    end else begin
      istat_reg <= (istat_reg & ~ev_clr) | ev_set;
      if (ctrl_wr) begin
        mode_reg <= avs_writedata[`BTA_CTRL_MODE_LSB +: 3];
        stop_reg <= avs_writedata[`BTA_CTRL_STOP];
      end
      if (wr_go & hit_tcount) begin
        tcount_reg <= tcount_merged[15:0];
      end
      if (wr_go & hit_imask & avs_byteenable[0]) begin
        imask_reg <= avs_writedata[`BTA_INT_W-1:0];
      end
      if (wr_go & hit_tidx & avs_byteenable[0]) begin
        tidx_reg <= avs_writedata[`BTA_PTR_W-1:0];
      end
    end
  end

  // Comparator criteria registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `BTA_NCMP; i++) begin
        cmp_cfg_reg[i] <= 32'h0000_0000;
        cmp_va_reg[i] <= 32'h0000_0000;
        cmp_vb_reg[i] <= 32'h0000_0000;
      end
    end else if (wr_go & hit_cmp) begin
      if (cmp_word == `BTA_CMP_CFG) begin
        cmp_cfg_reg[cmp_idx] <= be_merge(cmp_cfg_reg[cmp_idx], avs_writedata, avs_byteenable);
      end
      if (cmp_word == `BTA_CMP_VA) begin
        cmp_va_reg[cmp_idx] <= be_merge(cmp_va_reg[cmp_idx], avs_writedata, avs_byteenable);
      end
      if (cmp_word == `BTA_CMP_VB) begin
        cmp_vb_reg[cmp_idx] <= be_merge(cmp_vb_reg[cmp_idx], avs_writedata, avs_byteenable);
      end
    end
  end

  // Read selection; unmapped addresses read as zero
  wire bta_pkg::bta_sample_t tframe = trace_mem[tidx_reg];
  wire [31:0] ctrl_rd = {27'h0, stop_reg, mode_reg, 1'b0};
  wire [31:0] status_rd = {27'h0, wrapped_reg, state_reg == bta_pkg::BTA_DONE, in_post,
                           in_run | in_post, in_armed};
  wire [31:0] cmp_rd = (cmp_word == `BTA_CMP_CFG) ? cmp_cfg_reg[cmp_idx] :
                       (cmp_word == `BTA_CMP_VA) ? cmp_va_reg[cmp_idx] :
                       (cmp_word == `BTA_CMP_VB) ? cmp_vb_reg[cmp_idx] : 32'h0;
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                       hit_status ? status_rd :
                       hit_istat ? {29'h0, istat_reg} :
                       hit_imask ? {29'h0, imask_reg} :
                       hit_tcount ? {16'h0, tcount_reg} :
                       hit_remain ? {16'h0, cnt_reg} :
                       hit_stored ? {16'h0, stored_reg} :
                       hit_tidx ? {26'h0, tidx_reg} :
                       hit_tlo ? tframe[31:0] :
                       hit_thi ? {5'h00, tframe[58:32]} :
                       hit_cmp ? cmp_rd : 32'h0;

  // Handshake and read data flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (rd_first) begin
        readdata_reg <= rd_mux;
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_done_halt;
    halt_req && (state_reg == bta_pkg::BTA_DONE);
  endsequence

  sequence s_post_loaded;
    (state_reg == bta_pkg::BTA_POST) && (cnt_reg == $past(tcount_reg));
  endsequence

  AST_STORE_ON_CYCLE: assert property (store_en |-> tgt_cycle_end && tgt_running)
    else $error("store without a completed executed cycle");
  AST_ARMED_QUIET: assert property (in_armed && !tgt_running |-> !store_en)
    else $error("stored while armed before execution");
  AST_CONT_ALL: assert property (in_run && mode_reg == `BTA_MODE_CONT_ALL && exec_cyc
                                 |-> store_en)
    else $error("continuous all-cycles mode skipped a cycle");
  AST_EVENTS_ONLY: assert property (store_en && events_only |-> any_match)
    else $error("events-only mode stored a non-matching cycle");
  AST_COUNT_DEC: assert property (store_en && cnt_gate && !arm_load && !trigger
                                  |=> cnt_reg == $past(cnt_reg) - 16'h0001)
    else $error("down-counter did not step on a stored cycle");
  AST_TRIGGER_POST: assert property (trigger && !brk_stop && !halted && !ctrl_wr
                                     |=> s_post_loaded)
    else $error("trigger did not enter post-trigger phase");
  AST_BRK_HALT: assert property (exec_cyc && brk_hit |=> halt_req)
    else $error("breakpoint match did not request halt");
  AST_STOP_DONE: assert property (complete && stop_reg && !arm_load && !disarm
                                  |=> s_done_halt)
    else $error("completion with stop option did not halt");
  AST_PROBE_STORED: assert property (store_en |=> trace_mem[$past(wptr_reg)][58:35]
                                     == $past(tgt_probe))
    else $error("stored frame lacks probe levels");
  AST_COUNTED_END: assert property (in_run && counted && exec_cyc && cnt_zero && !ctrl_wr
                                    |-> !store_en ##1 state_reg == bta_pkg::BTA_DONE)
    else $error("counted mode ran past its count");
endmodule // bta_top

/* verif/bta_target_model.sv */
`timescale 1ns/10ps

// Stand-in for the target MCU: one bus cycle every two clocks
module bta_target_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Debugger side: start a run of a given length
  input wire logic go,
  input wire logic [15:0] ncyc,
  // Halt request from the analyzer
  input wire logic halt_req,
  // Target bus and probes
  output logic tgt_cycle_end,
  output logic tgt_running,
  output logic [23:0] tgt_addr,
  output logic [7:0] tgt_data,
  output logic tgt_rw,
  output logic tgt_instr,
  output logic tgt_ext,
  output logic [23:0] tgt_probe
);
  logic [15:0] cyc_reg; // Executed cycle number since go
  logic [23:0] addr_now; // Address of the current cycle
  logic last_cycle; // Final cycle of the run is on the bus

  assign addr_now = 24'h000100 + {8'h00, cyc_reg};
  assign last_cycle = tgt_cycle_end && (cyc_reg == ncyc - 16'h0001);
  // Idle bus shows inverted address so a stale value cannot pass for live
  assign tgt_addr = tgt_running ? addr_now : ~addr_now;
  assign tgt_data = cyc_reg[7:0] ^ 8'h5a;
  assign tgt_rw = cyc_reg[2];
  assign tgt_instr = cyc_reg[1];
  assign tgt_ext = cyc_reg[3];
  // Low sixteen probes follow the cycle number, upper eight invert its low byte
  assign tgt_probe = {~cyc_reg[7:0], cyc_reg};

  // Strobe runs free; execution ends on its count or on a halt
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tgt_cycle_end <= 1'b0;
      tgt_running <= 1'b0;
      cyc_reg <= 16'h0000;
    end else begin
      tgt_cycle_end <= ~tgt_cycle_end;
      if (go) begin
        tgt_running <= 1'b1;
        cyc_reg <= 16'h0000;
      end else if (tgt_running && (halt_req || last_cycle)) begin
        tgt_running <= 1'b0;
      end else if (tgt_running && tgt_cycle_end) begin
        cyc_reg <= cyc_reg + 16'h0001;
      end
    end
  end
endmodule // bta_target_model

/* verif/bta_top_test.sv */
`timescale 1ns/10ps
`include "bta_params.svh"

module bta_top_test;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tgt_cycle_end, tgt_running, tgt_rw, tgt_instr, tgt_ext;
  logic [23:0] tgt_addr;
  logic [23:0] tgt_probe;
  logic [7:0] tgt_data;
  logic halt_req, irq;
  logic go = 1'b0; // Run start pulse to the model
  logic [15:0] ncyc = 16'h0000; // Run length in target cycles
  logic [31:0] rd; // Last read data
  int failures = 0;
  int cmp_count = 0;
  int halts = 0; // Halt pulses seen

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  // Count halt pulses, one per high cycle
  always @(posedge sys_clk) if (halt_req === 1'b1) halts++;

  bta_top bta_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tgt_cycle_end(tgt_cycle_end),
    .tgt_running(tgt_running), .tgt_addr(tgt_addr), .tgt_data(tgt_data), .tgt_rw(tgt_rw),
    .tgt_instr(tgt_instr), .tgt_ext(tgt_ext), .tgt_probe(tgt_probe), .halt_req(halt_req),
    .irq(irq));

  bta_target_model bta_target_model_inst (.sys_clk(sys_clk), .reset_n(reset_n), .go(go),
    .ncyc(ncyc), .halt_req(halt_req), .tgt_cycle_end(tgt_cycle_end),
    .tgt_running(tgt_running), .tgt_addr(tgt_addr), .tgt_data(tgt_data), .tgt_rw(tgt_rw),
    .tgt_instr(tgt_instr), .tgt_ext(tgt_ext), .tgt_probe(tgt_probe));

  // Verdict and end of run
  task automatic results;
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compare one value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      failures++;
      results();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask

  // Interrupt line after the last write has landed
  task automatic irqchk(input logic exp);
    @(negedge sys_clk);
    check({31'h0, irq}, {31'h0, exp});
  endtask

  // Program one comparator: config, value a, value b
  task automatic cmp(input logic [1:0] n, input logic [31:0] c, input logic [31:0] va,
      input logic [31:0] vb);
    wr({2'b01, n, 4'h0}, c);
    wr({2'b01, n, 4'h4}, va);
    wr({2'b01, n, 4'h8}, vb);
  endtask

  // Clear flags, disable comparators, load the terminal count
  task automatic prep(input logic [15:0] tc);
    wr(`BTA_OFF_INT_STAT, 32'h00000007);
    for (int n = 0; n < 4; n++) cmp(n[1:0], 32'h00000000, 32'h00000000, 32'h00000000);
    wr(`BTA_OFF_TCOUNT, {16'h0000, tc});
  endtask

  task automatic arm(input logic [2:0] mode, input logic stop);
    wr(`BTA_OFF_CTRL, {27'h0, stop, mode, 1'b1});
  endtask

  // Let the target execute n cycles, wait until it stops
  task automatic run(input logic [15:0] n);
    int i;
    @(posedge sys_clk);
    ncyc <= n;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(negedge sys_clk);
      if (tgt_running === 1'b0) break;
    end
    if (i == 400) begin
      failures++;
      results();
    end
    repeat (4) @(posedge sys_clk);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Reset values and an unmapped hole
    rdchk(`BTA_OFF_INT_STAT, 32'h00000000);
    rdchk(`BTA_OFF_TCOUNT, {16'h0000, `BTA_TCOUNT_RST});
    wr(8'h30, 32'hffffffff);
    rdchk(8'h30, 32'h00000000);
    // Continuous all cycles; nothing stored while armed but not running
    prep(16'h0010);
    arm(`BTA_MODE_CONT_ALL, 1'b0);
    repeat (20) @(posedge sys_clk);
    rdchk(`BTA_OFF_STORED, 32'h00000000);
    run(16'd10);
    rdchk(`BTA_OFF_STORED, 32'h0000000a);
    wr(`BTA_OFF_TIDX, 32'h00000005);
    rdchk(`BTA_OFF_TLO, 32'h0001055f);
    bus(1'b0, `BTA_OFF_THI, 32'h00000000);
    check({5'h00, rd[26:0]}, {5'h00, 24'hfa0005, 3'b001});
    // Done flag, mask and write-one-to-clear
    rdchk(`BTA_OFF_INT_STAT, 32'h00000001);
    irqchk(1'b0);
    wr(`BTA_OFF_INT_MASK, 32'h00000001);
    irqchk(1'b1);
    wr(`BTA_OFF_INT_STAT, 32'h00000001);
    irqchk(1'b0);
    // Counted all cycles with stop on completion
    prep(16'h0004);
    arm(`BTA_MODE_CNT_ALL, 1'b1);
    halts = 0;
    run(16'd20);
    rdchk(`BTA_OFF_STORED, 32'h00000004);
    rdchk(`BTA_OFF_REMAIN, 32'h00000000);
    check(halts, 32'h00000001);
    // Events only; disabled A never matches, B wants addr[1:0]=1 and write
    prep(16'h0002);
    cmp(2'd0, 32'h00000000, 32'h00000000, 32'h00000000);
    cmp(2'd1, 32'h00000019, 32'h00000100, 32'h00000300);
    arm(`BTA_MODE_CONT_EV, 1'b0);
    run(16'd32);
    rdchk(`BTA_OFF_STORED, 32'h00000004);
    wr(`BTA_OFF_TIDX, 32'h00000001);
    rdchk(`BTA_OFF_TLO, 32'h00010d57);
    // Range on the 32-bit word, addresses 0x110 to 0x113
    prep(16'h0000);
    cmp(2'd3, 32'h00000003, 32'h00011000, 32'h000113ff);
    arm(`BTA_MODE_CONT_EV, 1'b0);
    run(16'd32);
    rdchk(`BTA_OFF_STORED, 32'h00000004);
    // Counted events on two probe lines with ext low
    prep(16'h0002);
    cmp(2'd2, 32'h0000c681, 32'h00000000, 32'h00000000);
    arm(`BTA_MODE_CNT_EV, 1'b0);
    run(16'd32);
    rdchk(`BTA_OFF_STORED, 32'h00000002);
    wr(`BTA_OFF_TIDX, 32'h00000001);
    rdchk(`BTA_OFF_TLO, 32'h0001075d);
    // Breakpoint at address 0x10a
    prep(16'h0000);
    cmp(2'd0, 32'h00000005, 32'h00010a00, 32'hffffff00);
    arm(`BTA_MODE_CONT_ALL, 1'b0);
    halts = 0;
    run(16'd40);
    rdchk(`BTA_OFF_STORED, 32'h0000000b);
    check(halts, 32'h00000001);
    bus(1'b0, `BTA_OFF_INT_STAT, 32'h00000000);
    check(rd & 32'h00000005, 32'h00000005);
    // Single event trigger at 0x108, three cycles after
    prep(16'h0003);
    cmp(2'd0, 32'h00000001, 32'h00010800, 32'hffffff00);
    arm(`BTA_MODE_SEQ_ANY, 1'b0);
    run(16'd40);
    rdchk(`BTA_OFF_STORED, 32'h0000000c);
    bus(1'b0, `BTA_OFF_INT_STAT, 32'h00000000);
    check(rd & 32'h00000002, 32'h00000002);
    results();
  end
endmodule // bta_top_test
